// ### wpd_wake_detector.sv
`timescale 1ns/1ps
module wpd_wake_detector #(
  parameter int ADDR_REPS = wpd_pkg::ADDR_REPS
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_sof,
  input  wire logic        rx_eof,
  input  wire logic [47:0] station_addr,
  input  wire logic        wake_enable,
  input  wire logic        host_asleep,
  input  wire logic        pme_ack,
  output logic             pme_req_q,
  output logic             wake_seen_q
);

  initial begin
    if (ADDR_REPS < 1 || ADDR_REPS > 32) begin
      $error("wpd_wake_detector: ADDR_REPS out of range");
    end
  end

  // =====================================================================
  // pin synchronisers: wake enable and sleep state come from the power well
  logic [1:0] cfg_meta_q;
  logic [1:0] cfg_sync_q;
  logic       enable_s;
  logic       asleep_s;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfg_meta_q <= 2'h0;
      cfg_sync_q <= 2'h0;
    end else begin
      cfg_meta_q <= {host_asleep, wake_enable};
      cfg_sync_q <= cfg_meta_q;
    end
  end

  assign enable_s = cfg_sync_q[0];
  assign asleep_s = cfg_sync_q[1];

  // =====================================================================
  // frame tracking
  logic       in_frame_q, in_frame_d;
  logic [3:0] pos_q, pos_d;
  logic       bcast_q, bcast_d;
  logic       end_q, end_d;
  logic       feed;
  logic       restart;
  logic       match_hit;

  always_comb begin
    in_frame_d = in_frame_q;
    pos_d      = pos_q;
    bcast_d    = bcast_q;
    end_d      = rx_valid & rx_eof;
    if (rx_valid) begin
      if (rx_sof) begin
        in_frame_d = ~rx_eof;
        pos_d      = 4'h1;
        bcast_d    = (rx_data == wpd_pkg::ONES_BYTE);
      end else if (in_frame_q) begin
        if (pos_q != wpd_pkg::HDR_LEN) begin
          pos_d = pos_q + 4'h1;
        end
        if (pos_q < wpd_pkg::DA_LEN) begin
          bcast_d = bcast_q & (rx_data == wpd_pkg::ONES_BYTE);
        end
        if (rx_eof) begin
          in_frame_d = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      in_frame_q <= 1'b0;
      pos_q      <= 4'h0;
      bcast_q    <= 1'b0;
      end_q      <= 1'b0;
    end else begin
      in_frame_q <= in_frame_d;
      pos_q      <= pos_d;
      bcast_q    <= bcast_d;
      end_q      <= end_d;
    end
  end

  // every payload byte of a broadcast frame enters the scan, headers unparsed
  assign feed    = rx_valid & in_frame_q & ~rx_sof & (pos_q == wpd_pkg::HDR_LEN)
                   & bcast_q;
  assign restart = (rx_valid & rx_sof) | end_q;

  wpd_seq_matcher #(
    .SYNC_LEN  (wpd_pkg::SYNC_LEN),
    .ADDR_REPS (ADDR_REPS)
  ) u_matcher (
    .sys_clk      (sys_clk),
    .srst         (srst),
    .byte_vld     (feed),
    .byte_data    (rx_data),
    .restart      (restart),
    .station_addr (station_addr),
    .hit_q        (match_hit)
  );

  // =====================================================================
  // wake request
  logic armed_q, armed_d;
  logic pme_d;
  logic seen_d;

  always_comb begin
    armed_d = asleep_s & enable_s;
    seen_d  = match_hit;
    // a new hit in the acknowledge cycle keeps the request up
    pme_d   = (pme_req_q & ~pme_ack) | (match_hit & armed_q);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      armed_q     <= 1'b0;
      pme_req_q   <= 1'b0;
      wake_seen_q <= 1'b0;
    end else begin
      armed_q     <= armed_d;
      pme_req_q   <= pme_d;
      wake_seen_q <= seen_d;
    end
  end

  // =====================================================================
  // check-only frame view, kept apart from the tracking logic it watches
  logic       chk_open_q, chk_open_d;
  logic [3:0] chk_cnt_q, chk_cnt_d;
  logic       chk_dst_q, chk_dst_d;

  always_comb begin
    chk_open_d = chk_open_q;
    chk_cnt_d  = chk_cnt_q;
    chk_dst_d  = chk_dst_q;
    if (rx_valid && rx_sof) begin
      chk_open_d = ~rx_eof;
      chk_cnt_d  = 4'h1;
      chk_dst_d  = (rx_data == wpd_pkg::ONES_BYTE);
    end else if (rx_valid && chk_open_q) begin
      chk_open_d = ~rx_eof;
      // saturates: only "inside the payload" matters past the header
      chk_cnt_d  = (chk_cnt_q == 4'hF) ? 4'hF : chk_cnt_q + 4'h1;
      chk_dst_d  = chk_dst_q
                   & ((chk_cnt_q >= wpd_pkg::DA_LEN) | (rx_data == wpd_pkg::ONES_BYTE));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      chk_open_q <= 1'b0;
      chk_cnt_q  <= 4'h0;
      chk_dst_q  <= 1'b0;
    end else begin
      chk_open_q <= chk_open_d;
      chk_cnt_q  <= chk_cnt_d;
      chk_dst_q  <= chk_dst_d;
    end
  end

  // =====================================================================
  // checks
  property p_wake_needs_enable;
    @(posedge sys_clk) disable iff (srst)
    $rose(pme_req_q) |-> $past(armed_q) && $past(match_hit);
  endproperty
  a_wake_needs_enable: assert property (p_wake_needs_enable)
    else $error("wake request without enable and match");

  property p_hit_raises_pme;
    @(posedge sys_clk) disable iff (srst)
    match_hit && armed_q |=> pme_req_q;
  endproperty
  a_hit_raises_pme: assert property (p_hit_raises_pme)
    else $error("armed match did not raise wake request");

  property p_pme_holds;
    @(posedge sys_clk) disable iff (srst)
    pme_req_q && !pme_ack |=> pme_req_q;
  endproperty
  a_pme_holds: assert property (p_pme_holds)
    else $error("wake request dropped before acknowledge");

  property p_armed_follows_pins;
    @(posedge sys_clk) disable iff (srst)
    host_asleep && wake_enable ##1 host_asleep && wake_enable ##1 host_asleep && wake_enable
      |=> armed_q;
  endproperty
  a_armed_follows_pins: assert property (p_armed_follows_pins)
    else $error("detector not armed while host asleep and enabled");

  property p_feed_bcast_only;
    @(posedge sys_clk) disable iff (srst)
    feed |-> chk_open_q && chk_dst_q && chk_cnt_q >= wpd_pkg::HDR_LEN;
  endproperty
  a_feed_bcast_only: assert property (p_feed_bcast_only)
    else $error("non-broadcast or header byte scanned");

  property p_payload_scanned;
    @(posedge sys_clk) disable iff (srst)
    rx_valid && !rx_sof && chk_open_q && chk_dst_q && chk_cnt_q >= wpd_pkg::HDR_LEN |-> feed;
  endproperty
  a_payload_scanned: assert property (p_payload_scanned)
    else $error("payload byte skipped by the scan");

  property p_seen_tracks_hit;
    @(posedge sys_clk) disable iff (srst)
    match_hit |=> wake_seen_q ##1 !wake_seen_q;
  endproperty
  a_seen_tracks_hit: assert property (p_seen_tracks_hit)
    else $error("match indication not a one-cycle pulse");

endmodule

// ### wpd_pkg.sv
package wpd_pkg;

  // =====================================================================
  // frame layout
  localparam logic [3:0] HDR_LEN    = 4'hE;  // destination, source, type
  localparam logic [3:0] DA_LEN     = 4'h6;  // destination address bytes
  localparam logic [7:0] ONES_BYTE  = 8'hFF;

  // =====================================================================
  // wake pattern
  localparam int         SYNC_LEN   = 6;
  localparam int         ADDR_REPS  = 16;
  localparam int         ADDR_BYTES = 6;

  typedef enum logic {
    WPD_SYNC = 1'b0,
    WPD_ADDR = 1'b1
  } wpd_phase_type;

endpackage

// ### wpd_seq_matcher.sv
`timescale 1ns/1ps
module wpd_seq_matcher #(
  parameter int SYNC_LEN  = wpd_pkg::SYNC_LEN,
  parameter int ADDR_REPS = wpd_pkg::ADDR_REPS
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        byte_vld,
  input  wire logic [7:0]  byte_data,
  input  wire logic        restart,
  input  wire logic [47:0] station_addr,
  output logic             hit_q
);

  initial begin
    if (SYNC_LEN < 2 || SYNC_LEN > 7 || ADDR_REPS < 1 || ADDR_REPS > 32) begin
      $error("wpd_seq_matcher: unsupported pattern length");
    end
  end

  wpd_pkg::wpd_phase_type phase_q, phase_d;
  logic [2:0] ones_q, ones_d;
  logic [2:0] idx_q, idx_d;
  logic [4:0] rep_q, rep_d;
  logic       hit_d;
  logic [7:0] addr_byte;

  // =====================================================================
  // sequence scan
  always_comb begin
    addr_byte = station_addr[{3'(3'd5 - idx_q), 3'b000} +: 8];  // first byte is the msb
    phase_d   = phase_q;
    ones_d    = ones_q;
    idx_d     = idx_q;
    rep_d     = rep_q;
    hit_d     = 1'b0;
    if (restart) begin
      phase_d = wpd_pkg::WPD_SYNC;
      ones_d  = 3'h0;
      idx_d   = 3'h0;
      rep_d   = 5'h00;
    end else if (byte_vld) begin
      case (phase_q)
        wpd_pkg::WPD_SYNC: begin
          if (byte_data == wpd_pkg::ONES_BYTE) begin
            if (ones_q == 3'(SYNC_LEN - 1)) begin
              phase_d = wpd_pkg::WPD_ADDR;
              idx_d   = 3'h0;
              rep_d   = 5'h00;
            end else begin
              ones_d = ones_q + 3'h1;
            end
          end else begin
            ones_d = 3'h0;
          end
        end
        wpd_pkg::WPD_ADDR: begin
          if (byte_data == addr_byte) begin
            if (idx_q == 3'(wpd_pkg::ADDR_BYTES - 1)) begin
              idx_d = 3'h0;
              if (rep_q == 5'(ADDR_REPS - 1)) begin
                hit_d   = 1'b1;
                phase_d = wpd_pkg::WPD_SYNC;
                ones_d  = 3'h0;
              end else begin
                rep_d = rep_q + 5'h01;
              end
            end else begin
              idx_d = idx_q + 3'h1;
            end
          end else if (byte_data == wpd_pkg::ONES_BYTE) begin
            // a longer run of ones still leaves a valid sync in place
            if (idx_q != 3'h0 || rep_q != 5'h00) begin
              phase_d = wpd_pkg::WPD_SYNC;
              ones_d  = 3'h1;
            end
          end else begin
            phase_d = wpd_pkg::WPD_SYNC;
            ones_d  = 3'h0;
          end
        end
        default: begin
          phase_d = wpd_pkg::WPD_SYNC;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      phase_q <= wpd_pkg::WPD_SYNC;
      ones_q  <= 3'h0;
      idx_q   <= 3'h0;
      rep_q   <= 5'h00;
      hit_q   <= 1'b0;
    end else begin
      phase_q <= phase_d;
      ones_q  <= ones_d;
      idx_q   <= idx_d;
      rep_q   <= rep_d;
      hit_q   <= hit_d;
    end
  end

  // =====================================================================
  // checks
  property p_hit_after_full_seq;
    @(posedge sys_clk) disable iff (srst)
    hit_q |-> $past(phase_q == wpd_pkg::WPD_ADDR && rep_q == 5'(ADDR_REPS - 1)
                    && idx_q == 3'(wpd_pkg::ADDR_BYTES - 1) && byte_vld && !restart);
  endproperty
  a_hit_after_full_seq: assert property (p_hit_after_full_seq)
    else $error("hit without a complete pattern");

  property p_restart_clears;
    @(posedge sys_clk) disable iff (srst)
    restart |=> phase_q == wpd_pkg::WPD_SYNC && ones_q == 3'h0 && !hit_q;
  endproperty
  a_restart_clears: assert property (p_restart_clears)
    else $error("partial match survived a restart");

  property p_break_resyncs;
    @(posedge sys_clk) disable iff (srst)
    byte_vld && !restart && phase_q == wpd_pkg::WPD_ADDR && byte_data != addr_byte
      && byte_data != wpd_pkg::ONES_BYTE
      |=> phase_q == wpd_pkg::WPD_SYNC && ones_q == 3'h0;
  endproperty
  a_break_resyncs: assert property (p_break_resyncs)
    else $error("mismatch did not restart the scan");

endmodule

// ### wpd_frame_src.sv
`timescale 1ns/1ps
// =====================================================================
// remote station model
module wpd_frame_src (
  input  wire logic       sys_clk,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_sof,
  output logic            rx_eof
);
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    rx_sof   = 1'b0;
    rx_eof   = 1'b0;
  end

  // idle data inverts on every gap cycle and once after the last byte, and valid drops, so stale bytes never look valid
  task automatic send(input logic [7:0] f[$], input int gap_max);
    int g;
    for (int i = 0; i < f.size(); i++) begin
      g = $urandom_range(gap_max, 0);
      repeat (g) begin
        @(negedge sys_clk);
        rx_valid = 1'b0;
        rx_data  = ~rx_data;
      end
      @(negedge sys_clk);
      rx_valid = 1'b1;
      rx_data  = f[i];
      rx_sof   = (i == 0);
      rx_eof   = (i == f.size() - 1);
    end
    @(negedge sys_clk);
    rx_valid = 1'b0;
    rx_sof   = 1'b0;
    rx_eof   = 1'b0;
    rx_data  = ~rx_data;
  endtask
endmodule

// ### wpd_wake_detector_tb_top.sv
`timescale 1ns/1ps
module wpd_wake_detector_tb_top;
  localparam int REPS = 16;
  logic        sys_clk, srst, rx_valid, rx_sof, rx_eof;
  logic [7:0]  rx_data;
  logic [47:0] station_addr;
  logic        wake_enable, host_asleep, pme_ack, pme_req_q, wake_seen_q;
  logic        exp_req;
  logic [7:0]  frm[$];
  int          errors, total_checks, hits;

  wpd_frame_src i_wpd_frame_src (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_sof(rx_sof), .rx_eof(rx_eof));
  wpd_wake_detector #(.ADDR_REPS(REPS)) i_wpd_wake_detector (.sys_clk(sys_clk), .srst(srst),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_sof(rx_sof), .rx_eof(rx_eof),
    .station_addr(station_addr), .wake_enable(wake_enable), .host_asleep(host_asleep),
    .pme_ack(pme_ack), .pme_req_q(pme_req_q), .wake_seen_q(wake_seen_q));

  always #20 sys_clk = ~sys_clk;
  // counting high cycles also catches a pulse that sticks
  always @(negedge sys_clk) if (wake_seen_q === 1'b1) hits++;

  // =====================================================================
  // reference scan
  function automatic int ref_hits(input logic [7:0] f[$]);
    int s, m, h;
    s = 0;
    m = 0;
    h = 0;
    for (int i = 0; i < 6; i++) if (f[i] != 8'hFF) return 0;
    for (int i = 14; i < f.size(); i++) begin
      if (s < 6) s = (f[i] == 8'hFF) ? s + 1 : 0;
      else if (f[i] == station_addr[47-8*(m%6) -: 8]) begin
        m++;
        if (m == 6 * REPS) begin
          h++;
          s = 0;
          m = 0;
        end
      end else if (!(m == 0 && f[i] == 8'hFF)) begin
        s = (f[i] == 8'hFF);
        m = 0;
      end
    end
    return h;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // =====================================================================
  // scenarios
  task automatic run(input bit bc, input int reps, input int brk, input bit slp, input bit en,
                     input int off, input int gap);
    int h;
    @(negedge sys_clk);
    for (int b = 0; b < 6; b++) station_addr[8*b +: 8] = 8'($urandom_range(254, 0));
    host_asleep = slp;
    wake_enable = en;
    repeat (4) @(negedge sys_clk);
    frm = {};
    for (int i = 0; i < 6; i++) frm.push_back((bc || i != 3) ? 8'hFF : 8'h5A);
    for (int i = 0; i < 6; i++) frm.push_back(8'($urandom_range(254, 0)));
    frm.push_back(8'h08);
    frm.push_back(8'h00);
    for (int i = 0; i < off; i++) frm.push_back(8'($urandom_range(254, 0)));
    if (brk != 2) begin
      frm.push_back(8'h00);
      frm.push_back(8'h09);
      repeat (6) frm.push_back(8'hFF);
    end
    if (brk == 1) begin
      frm.push_back(station_addr[47:40]);
      repeat (6) frm.push_back(8'hFF);
    end
    repeat (reps) for (int b = 5; b >= 0; b--) frm.push_back(station_addr[8*b +: 8]);
    if (brk != 3) frm.push_back(8'h11);
    h = ref_hits(frm);
    hits = 0;
    i_wpd_frame_src.send(frm, gap);
    repeat (4) @(negedge sys_clk);
    // an acknowledge held as a level clears the request one cycle after the hit raises it
    exp_req = (exp_req | (h > 0 && slp && en)) & ~pme_ack;
    check(32'(hits), 32'(h));
    check(32'(pme_req_q), 32'(exp_req));
  endtask

  task automatic ack;
    @(negedge sys_clk);
    pme_ack = 1'b1;
    @(negedge sys_clk);
    pme_ack = 1'b0;
    exp_req = 1'b0;
    check(32'(pme_req_q), 32'h0);
  endtask

  initial begin
    sys_clk = 1'b0;
    srst = 1'b1;
    wake_enable = 1'b0;
    host_asleep = 1'b0;
    pme_ack = 1'b0;
    exp_req = 1'b0;
    errors = 0;
    total_checks = 0;
    void'($urandom(32'hE985));
    for (int b = 0; b < 6; b++) station_addr[8*b +: 8] = 8'($urandom_range(254, 0));
    repeat (5) @(negedge sys_clk);
    srst = 1'b0;
    check(32'(pme_req_q), 32'h0);
    check(32'(wake_seen_q), 32'h0);
    for (int k = 0; k < 6; k++) run(1, 16, 0, 1, 1, $urandom_range(40, 0), $urandom_range(2, 0));
    ack();
    ack();
    run(0, 16, 0, 1, 1, 3, 1);
    // frame ends after fifteen copies; the next payload opens with one copy of a newly drawn address
    run(1, 15, 3, 1, 1, 0, 0);
    run(1, 1, 2, 1, 1, 0, 0);
    run(1, 16, 1, 1, 1, 5, 0);
    // reset in mid-run drops a pending wake request
    @(negedge sys_clk);
    srst = 1'b1;
    repeat (3) @(negedge sys_clk);
    srst = 1'b0;
    exp_req = 1'b0;
    check(32'(pme_req_q), 32'h0);
    check(32'(wake_seen_q), 32'h0);
    run(1, 16, 0, 1, 1, 4, 2);
    ack();
    // acknowledge held through the hit
    pme_ack = 1'b1;
    run(1, 16, 0, 1, 1, 1, 0);
    pme_ack = 1'b0;
    run(1, 16, 0, 1, 0, 7, 1);
    run(1, 16, 0, 0, 1, 2, 0);
    tally_and_finish();
  end

  initial begin
    #2000000;
    errors++;
    tally_and_finish();
  end
endmodule
